// >>> dv/apmc_host.sv
/* apmc_host: processor model driving the converter strobes.
   Assumes the device clock; strobes move 5 ns after its edge. */
`timescale 1ns/100ps
`default_nettype none
module apmc_host (
  input  wire logic        clock_i, // clock
  input  wire logic [13:0] data_i, // result lines
  output logic             cs_n_o, // select
  output logic             wr_n_o, // write
  output logic             rd_n_o, // read
  output logic             cv_n_o, // start
  output logic [3:0]       ctl_o // control
);
  initial {cs_n_o, wr_n_o, rd_n_o, cv_n_o, ctl_o} = 8'hF0;
  task automatic tick(input int n = 1); repeat (n) @(posedge clock_i); #5; endtask
  task automatic write(input logic [3:0] w);
    {cs_n_o, wr_n_o, ctl_o} = {2'b00, w}; tick(); wr_n_o = 1'b1; tick();
    {cs_n_o, ctl_o} = {1'b1, ~w}; tick(2); // released lines must not look held
  endtask
  task automatic start(); // caller waits for ready
    cv_n_o = 1'b0; tick(); cv_n_o = 1'b1; tick();
  endtask
  task automatic read(input bit last, output logic [13:0] d);
    {cs_n_o, rd_n_o} = 2'b00; tick(2); d = data_i;
    {cs_n_o, rd_n_o} = {last, 1'b1}; tick(); // select stays low across a burst
  endtask
endmodule
`default_nettype wire

// >>> dv/apmc_properties.sv
/* apmc_properties: port checks bound into apmc_top.
   Assumes host strobes change between clock edges. */
`timescale 1ns/100ps
`default_nettype none
module apmc_properties (
  input wire logic       clock_i, // clock
  input wire logic       reset_n_i, // reset
  input wire logic       cs_n_i, // select
  input wire logic       wr_n_i, // write
  input wire logic       rd_n_i, // read
  input wire logic       convert_start_strobe_n_i, // start
  input wire logic [3:0] control_word_bits_i, // mode
  input wire logic       done_n_o, // done
  input wire logic       core_on_o, // on
  input wire logic       bank_b_o, // bank
  input wire logic       ready_o, // ready
  input wire logic       result_oe_o // data drive
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence wend; !$past(cs_n_i) && !$past(wr_n_i) && (cs_n_i || wr_n_i); endsequence
  sequence go; $rose(convert_start_strobe_n_i) && ready_o; endsequence
  rst_done_a: assert property ($rose(reset_n_i) |-> done_n_o) else $error("done low");
  pd_on_a: assert property (wend ##0 control_word_bits_i[3] |-> ##2 !core_on_o)
    else $error("still powered");
  pd_bank_a: assert property (wend ##0 control_word_bits_i[3] |->
    ##2 bank_b_o == $past(bank_b_o, 2)) else $error("bank moved");
  wake_mode_a: assert property (wend ##0 !control_word_bits_i[3] |-> ##2 core_on_o &&
    bank_b_o == $past(control_word_bits_i[2], 2)) else $error("wake mode wrong");
  start_busy_a: assert property (go |-> ##[1:3] !ready_o) else $error("start not taken");
  conv_time_a: assert property (go |-> ##[55:250] !done_n_o)
    else $error("no done flag");
  rd_clr_a: assert property ($fell(rd_n_i) && !cs_n_i |-> ##[1:2] done_n_o)
    else $error("done not cleared");
  pd_rdy_a: assert property (!core_on_o |-> !ready_o) else $error("ready while off");
  read_drive_a: assert property (result_oe_o == (!cs_n_i && !rd_n_i))
    else $error("data drive wrong");
  cover property (wend ##0 control_word_bits_i[3]);
  cover property ($fell(done_n_o));
  cover property ($fell(rd_n_i) && !cs_n_i);
endmodule
bind apmc_top apmc_properties u_props (.clock_i, .reset_n_i, .cs_n_i, .wr_n_i, .rd_n_i,
  .convert_start_strobe_n_i, .control_word_bits_i, .done_n_o, .core_on_o, .bank_b_o, .ready_o,
  .result_oe_o);
`default_nettype wire

// >>> dv/apmc_top_tb.sv
/* apmc_top_tb: self-checking bench for apmc_top through the host model.
   Assumes a 20 MHz clock; samples are bench words, inverted for the power-down test. */
`timescale 1ns/100ps
`default_nettype none
module apmc_top_tb import apmc_pkg::*; ;
  logic                 clock_i = 1'b0;
  logic                 reset_n_i = 1'b0;
  logic [NCH*RES_W-1:0] sample_i = {14'h0001, 14'h1FFF, 14'h2000, 14'h3FFF};
  logic [RES_W-1:0]     result_bits_o;
  logic [3:0]           control_word_bits_i;
  logic                 cs_n_i, wr_n_i, rd_n_i, convert_start_strobe_n_i;
  logic                 done_n_o, core_on_o, bank_b_o, ready_o, result_oe_o;
  int                   err_total = 0, tests_run = 0, cyc = 0;
  initial forever #25 clock_i = ~clock_i;
  apmc_top u_dut (.clock_i, .reset_n_i, .cs_n_i, .wr_n_i, .rd_n_i, .convert_start_strobe_n_i,
    .control_word_bits_i, .sample_i, .result_bits_o, .result_oe_o, .done_n_o, .core_on_o,
    .bank_b_o, .ready_o);
  apmc_host u_host (.clock_i, .data_i(result_bits_o), .cs_n_o(cs_n_i), .wr_n_o(wr_n_i),
    .rd_n_o(rd_n_i), .cv_n_o(convert_start_strobe_n_i), .ctl_o(control_word_bits_i));
  task automatic chk(input string nm, input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_rdy(output int t);
    for (t = 0; ready_o !== 1'b1 && t < 300; t++) u_host.tick();
  endtask
  task automatic conv(input int n); // n+1 reads show the pointer wrap
    int t;
    logic [13:0] d;
    wait_rdy(t);
    u_host.start();
    u_host.tick(10);
    u_host.start(); // lands mid-sequence
    for (t = 12; done_n_o !== 1'b0 && t < 400; t++) u_host.tick();
    chk("conv", 14'(t >= n * CONV_CYC - 2 && t <= n * CONV_CYC + 4), 14'h1);
    for (int i = 0; i <= n; i++) begin
      u_host.read(i == n, d);
      chk("data", d, sample_i[(i % n) * RES_W +: RES_W]);
    end
    chk("done", 14'(done_n_o), 14'h1);
    chk("oe", 14'(result_oe_o), 14'h0);
  endtask
  task automatic t_reset();
    int t;
    chk("rst", 14'({done_n_o, core_on_o, bank_b_o, ready_o}), 14'hC);
    chk("rst_data", result_bits_o, 14'h0);
    wait_rdy(t);
    chk("por", 14'(t >= POR_CYC - 3 && t <= POR_CYC + 3), 14'h1);
    conv(1);
    $display("reset test finished");
  endtask
  task automatic t_modes();
    for (int m = 7; m >= 0; m--) begin
      u_host.write(4'(m));
      chk("bank", 14'(bank_b_o), 14'(m / 4));
      conv(m % 4 + 1);
    end
    $display("mode test finished");
  endtask
  task automatic t_pd();
    sample_i = ~sample_i;
    u_host.write(4'h6);
    u_host.write(4'h8); // low bits must not reach the mode
    chk("pd", 14'({core_on_o, bank_b_o, ready_o}), 14'h2);
    u_host.start();
    u_host.tick(300);
    chk("pd_done", 14'(done_n_o), 14'h1);
    u_host.write(4'h1);
    chk("wake", 14'({core_on_o, bank_b_o}), 14'h2);
    u_host.tick(POR_CYC); // reference settles before the next start
    conv(2);
    $display("power-down test finished");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clock_i);
    #5 reset_n_i = 1'b1;
    t_reset();
    t_modes();
    t_pd();
    print_verdict();
  end
endmodule
`default_nettype wire

// >>> hdl/apmc_edge.sv
/*
  apmc_edge: rising and falling edge detector for a strobe sampled on clock_i.
  Assumes the strobe is already synchronous to clock_i.
*/
`timescale 1ns/100ps
`default_nettype none
module apmc_edge (
  input  wire logic clock_i,   // system clock
  input  wire logic reset_n_i, // async reset, active low
  input  wire logic sig_i,     // sampled strobe
  output logic      rise_o,    // one-cycle rising edge
  output logic      fall_o     // one-cycle falling edge
);
  logic prev_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= sig_i;
    end
  end
  assign rise_o = sig_i & ~prev_q;
  assign fall_o = ~sig_i & prev_q;
endmodule
`default_nettype wire

// >>> hdl/apmc_top.sv
/*
  apmc_top: power and mode control, sequencer and result readout for a
  four-channel 14-bit converter.
  Assumes strobes synchronous to clock_i; the analog core supplies one sample
  per channel on sample_i and the bidirectional bus is resolved outside.
*/
// What this block does
// - after reset done flag high, ready after the 5 us reset interval
// - reset mode is bank A, one channel
// - result memory undefined until first conversion
// - power-down when control bit 3 set
// - power-down acts on write latch edge
// - powered down: core off, interface alive
// - bit 3 zero wakes, lower bits mode
// - results are two's-complement 14-bit values
// - control word latched on write/select rise
// - bank bit, one to four channels, 3 us each
// - ignore convert starts while sequence runs
// - read rise advances pointer, wraps after n
`timescale 1ns/100ps
`default_nettype none
module apmc_top
  import apmc_pkg::*;
(
  input  wire logic                    clock_i,        // system clock, 20 MHz
  input  wire logic                    reset_n_i,      // async reset, active low
  input  wire logic                    cs_n_i,         // chip select, active low
  input  wire logic                    wr_n_i,         // write strobe, active low
  input  wire logic                    rd_n_i,         // read strobe, active low
  input  wire logic                    convert_start_strobe_n_i, // start, active low
  input  wire logic [3:0]              control_word_bits_i,  // low data lines in
  input  wire logic [NCH*RES_W-1:0]    sample_i,       // held samples, ch1 lowest
  output logic [RES_W-1:0]             result_bits_o,  // result word out
  output logic                         result_oe_o,    // drive data lines
  output logic                         done_n_o,       // done flag, active low
  output logic                         core_on_o,      // conversion logic powered
  output logic                         bank_b_o,       // bank B selected
  output logic                         ready_o         // accepts a start
);
  apmc_state_e              state_q, state_d;
  apmc_ctrl_s               ctrl_q;
  logic [CNT_W-1:0]         cnt_q;
  logic [1:0]               ch_q;
  logic [1:0]               ptr_q;
  logic                     done_n_q;
  logic [RES_W-1:0]         mem_q [NCH];
  logic [RES_W-1:0]         out_q;
  logic                     wr_act, cs_act_rd;
  logic                     wr_rise;
  logic                     rd_rise, rd_fall;
  logic                     cv_rise;
  logic                     wr_latch, start_ok, conv_tick, seq_last;
  logic                     wr_sel_q;

  // write strobe qualified by select, and read strobe qualified by select
  assign wr_act    = ~cs_n_i & ~wr_n_i;
  assign cs_act_rd = ~cs_n_i & ~rd_n_i;

  apmc_edge u_wr (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .sig_i     (~wr_act),
    .rise_o    (wr_rise),
    .fall_o    ()
  );
  apmc_edge u_rd (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .sig_i     (~cs_act_rd),
    .rise_o    (rd_rise),
    .fall_o    (rd_fall)
  );
  apmc_edge u_cv (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .sig_i     (convert_start_strobe_n_i),
    .rise_o    (cv_rise),
    .fall_o    ()
  );

  // the end of the combined low window covers either wr or cs rising first
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_sel_q <= 1'b0;
    end else begin
      wr_sel_q <= wr_act;
    end
  end
  assign wr_latch = wr_rise & wr_sel_q;

  assign start_ok  = (state_q == APMC_IDLE) & ~ctrl_q.power_down;
  assign conv_tick = (cnt_q == CNT_W'(CONV_CYC - 1));
  assign seq_last  = conv_tick & (ch_q == ctrl_q.nch_m1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      APMC_RST:  if (cnt_q == CNT_W'(POR_CYC - 1)) state_d = APMC_IDLE;
      APMC_IDLE: if (cv_rise && start_ok) state_d = APMC_CONV;
      APMC_CONV: begin
        if (ctrl_q.power_down) state_d = APMC_IDLE;
        else if (seq_last) state_d = APMC_IDLE;
      end
      default:   state_d = APMC_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= APMC_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // control word; power-down takes hold on the latching edge itself
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= apmc_ctrl_s'(CTRL_RESET);
    end else if (wr_latch) begin
      ctrl_q.power_down <= control_word_bits_i[PD_POS];
      if (!control_word_bits_i[PD_POS]) begin
        ctrl_q.bank_b <= control_word_bits_i[BANK_POS];
        ctrl_q.nch_m1 <= control_word_bits_i[NSEL_LSB +: 2];
      end
    end
  end

  // cycle counter: reset interval, then 3 us per channel
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      ch_q  <= '0;
    end else if (state_q == APMC_RST) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end else if (state_q == APMC_CONV && !ctrl_q.power_down) begin
      cnt_q <= conv_tick ? '0 : cnt_q + CNT_W'(1);
      if (conv_tick) begin
        ch_q <= ch_q + 2'h1;
      end
    end else begin
      cnt_q <= '0;
      ch_q  <= '0;
    end
  end

  // result memory is never cleared, so it is undefined before a conversion
  always_ff @(posedge clock_i) begin
    if (state_q == APMC_CONV && conv_tick && !ctrl_q.power_down) begin
      mem_q[ch_q] <= sample_i[ch_q*RES_W +: RES_W];
    end
  end

  // done flag low after last channel; first read falling edge clears it
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_n_q <= 1'b1;
    end else if (state_q == APMC_CONV && seq_last && !ctrl_q.power_down) begin
      done_n_q <= 1'b0;
    end else if (rd_fall || cv_rise) begin
      done_n_q <= 1'b1;
    end
  end

  // pointer wraps to channel one after n reads; the last channel of a sequence rewinds it
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_q <= '0;
    end else if (state_q == APMC_CONV && seq_last) begin
      ptr_q <= '0;
    end else if (rd_rise) begin
      ptr_q <= (ptr_q == ctrl_q.nch_m1) ? 2'h0 : ptr_q + 2'h1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_q <= '0;
    end else if (rd_fall) begin
      out_q <= mem_q[ptr_q];
    end
  end

  assign result_bits_o = out_q;
  assign result_oe_o   = cs_act_rd;
  assign done_n_o      = done_n_q;
  assign core_on_o     = ~ctrl_q.power_down;
  assign bank_b_o      = ctrl_q.bank_b;
  assign ready_o       = start_ok;
endmodule
`default_nettype wire

// >>> shared/apmc_pkg.sv
/*
  apmc_pkg: constants and carrier types for the converter power and mode control block.
  Assumes a 20 MHz system clock.
*/
`default_nettype none
package apmc_pkg;
  localparam int unsigned CLK_NS        = 50;
  localparam int unsigned POR_TIME_NS   = 5000;
  localparam int unsigned CONV_TIME_NS  = 3000;
  localparam int unsigned POR_CYC       = (POR_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CONV_CYC      = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned RES_W         = 14;
  localparam int unsigned NCH           = 4;
  localparam int unsigned PD_POS        = 3;
  localparam int unsigned BANK_POS      = 2;
  localparam int unsigned NSEL_LSB      = 0;
  localparam logic [3:0]  CTRL_RESET    = 4'h0;

  typedef struct packed {
    logic       power_down;
    logic       bank_b;
    logic [1:0] nch_m1;
  } apmc_ctrl_s;

  typedef enum logic [1:0] {
    APMC_RST  = 2'b00,
    APMC_IDLE = 2'b01,
    APMC_CONV = 2'b10
  } apmc_state_e;
endpackage
`default_nettype wire
